// ---- core/hps_port.sv ----
// Host side status, vector and data byte registers of a 24-bit host port
// Notes on behaviour
// - Word moved in from DSP transmit side sets receive-full, status bit 0
// - Host read of address 7 clears receive-full
// - Moving transmit bytes to DSP receive side sets transmit-empty, bit 1
// - Host write to address 7 clears transmit-empty
// - Initialize command clears receive-full if receive request enabled, sets transmit-empty if transmit request enabled
// - Flags drive requests only when enabled; always readable by polling
// - Transmitter ready is transmit-empty and not DSP receive-full
// - Three bytes move as one word when both flags clear; sets both
// - Status bits 3 and 4 mirror DSP flags; host cannot change them
// - Status bits 5 and 6 read zero; host should write zero
// - Status bit 7 follows combined or dual request outputs per select
// - Request status is one when any flag and its enable are set
// - Vector register host only; driven on acknowledge during combined or transmit request
// - Vector resets to 0f on hard or soft reset, else kept
// - Receive bytes read-only, carry high, middle, low of DSP word
// - Little endian puts receive high at 7, low at 5; big swaps
// - Transmit bytes write-only, feed high, middle, low of DSP word
// - Big endian puts transmit high at 5, low at 7; little swaps
// - Clearing interface enable or stop performs an individual reset
// - Every reset sets empty and ready, clears full, empties bytes
// - Host writes to status address change nothing
`timescale 1ns/1ps
`default_nettype none

module hps_port (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        soft_rst,
  input  wire logic        stop_rst,
  input  wire logic        interface_enable,
  input  wire logic [2:0]  host_addr,
  input  wire logic        host_rd,
  input  wire logic        host_wr,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe,
  input  wire logic        host_acknowledge_in,
  input  wire logic        receive_request_enable,
  input  wire logic        transmit_request_enable,
  input  wire logic        byte_order_select,
  input  wire logic        dual_request_select,
  input  wire logic        init_cmd,
  input  wire logic        dsp_flag_two,
  input  wire logic        dsp_flag_three,
  input  wire logic [23:0] dsp_side_transmit_word,
  input  wire logic        dsp_tx_write,
  output logic      [23:0] dsp_side_receive_word,
  output logic             dsp_side_receive_full,
  input  wire logic        dsp_rx_read,
  output logic             rx_full_flag,
  output logic             tx_empty_flag,
  output logic             transmitter_ready,
  output logic             combined_request_out,
  output logic             transmit_request_out,
  output logic             receive_request_out
);

  // Lane served by a data address under the given byte order
  function automatic hps_pkg::hps_lane_t lane_of(
    input logic [2:0] addr,
    input logic       little
  );
    hps_pkg::hps_lane_t lane;
    lane = hps_pkg::HPS_LANE_NONE;
    if (addr == hps_pkg::ADDR_BYTE_A) begin
      lane = little ? hps_pkg::HPS_LANE_LOW : hps_pkg::HPS_LANE_HIGH;
    end else if (addr == hps_pkg::ADDR_BYTE_B) begin
      lane = hps_pkg::HPS_LANE_MID;
    end else if (addr == hps_pkg::ADDR_BYTE_C) begin
      lane = little ? hps_pkg::HPS_LANE_HIGH : hps_pkg::HPS_LANE_LOW;
    end
    return lane;
  endfunction : lane_of

  // Byte of a word picked by lane
  function automatic logic [7:0] pick_byte(
    input logic [23:0]        word,
    input hps_pkg::hps_lane_t lane
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (lane)
      hps_pkg::HPS_LANE_HIGH: b = word[23:16];
      hps_pkg::HPS_LANE_MID:  b = word[15:8];
      hps_pkg::HPS_LANE_LOW:  b = word[7:0];
      hps_pkg::HPS_LANE_NONE: b = 8'h00;
    endcase
    return b;
  endfunction : pick_byte

  logic [23:0] rx_word;
  logic [23:0] tx_word;
  logic [7:0]  vector;
  logic        flag_two;
  logic        flag_three;

  logic        next_rx_full;
  logic        next_tx_empty;
  logic        next_dsp_full;
  logic        next_rx_req;
  logic        next_tx_req;
  logic        part_rst;
  logic        load_rx;
  logic        move_tx;
  logic        init_rx;
  logic        init_tx;
  logic        rd_last;
  logic        wr_last;
  logic        req_now;
  logic        vector_cycle;
  logic [7:0]  status;
  logic [7:0]  read_value;

  hps_pkg::hps_lane_t rd_lane;
  hps_pkg::hps_lane_t wr_lane;

  // Individual and stop resets act through the clock
  assign part_rst = soft_rst | stop_rst | ~interface_enable;

  assign rd_lane = lane_of(host_addr, byte_order_select);
  assign wr_lane = lane_of(host_addr, byte_order_select);

  assign rd_last = host_rd & (host_addr == hps_pkg::ADDR_BYTE_C);
  assign wr_last = host_wr & (host_addr == hps_pkg::ADDR_BYTE_C);
  assign init_rx = init_cmd & receive_request_enable;
  assign init_tx = init_cmd & transmit_request_enable;

  // New DSP word only lands on empty receive bytes
  assign load_rx = dsp_tx_write & ~rx_full_flag;

  // Word moves once host side is full and DSP side empty
  assign move_tx = ~tx_empty_flag & ~dsp_side_receive_full;

  // Flag updates; a hardware set wins over a clear in the same cycle
  always_comb begin
    next_rx_full = rx_full_flag;
    if (rd_last) begin
      next_rx_full = 1'b0;
    end
    if (init_rx) begin
      next_rx_full = 1'b0;
    end
    if (load_rx) begin
      next_rx_full = 1'b1;
    end
    if (part_rst) begin
      next_rx_full = 1'b0;
    end
  end

  always_comb begin
    next_tx_empty = tx_empty_flag;
    if (wr_last) begin
      next_tx_empty = 1'b0;
    end
    if (init_tx || move_tx) begin
      next_tx_empty = 1'b1;
    end
    if (part_rst) begin
      next_tx_empty = 1'b1;
    end
  end

  always_comb begin
    next_dsp_full = dsp_side_receive_full;
    if (dsp_rx_read || init_tx) begin
      next_dsp_full = 1'b0;
    end
    if (move_tx) begin
      next_dsp_full = 1'b1;
    end
    if (part_rst) begin
      next_dsp_full = 1'b0;
    end
  end

  assign next_rx_req = next_rx_full & receive_request_enable;
  assign next_tx_req = next_tx_empty & transmit_request_enable;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_full_flag          <= 1'b0;
      tx_empty_flag         <= 1'b1;
      dsp_side_receive_full <= 1'b0;
      transmitter_ready     <= 1'b1;
    end else begin
      rx_full_flag          <= next_rx_full;
      tx_empty_flag         <= next_tx_empty;
      dsp_side_receive_full <= next_dsp_full;
      transmitter_ready     <= next_tx_empty & ~next_dsp_full;
    end
  end

  // Receive bytes: loaded whole from the DSP transmit word
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_word <= hps_pkg::WORD_EMPTY;
    end else if (part_rst) begin
      rx_word <= hps_pkg::WORD_EMPTY;
    end else if (load_rx) begin
      rx_word <= dsp_side_transmit_word;
    end
  end

  // Transmit bytes: host writes a lane at a time
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_word <= hps_pkg::WORD_EMPTY;
    end else if (part_rst) begin
      tx_word <= hps_pkg::WORD_EMPTY;
    end else if (host_wr) begin
      unique case (wr_lane)
        hps_pkg::HPS_LANE_HIGH: tx_word[23:16] <= host_data_in;
        hps_pkg::HPS_LANE_MID:  tx_word[15:8]  <= host_data_in;
        hps_pkg::HPS_LANE_LOW:  tx_word[7:0]   <= host_data_in;
        hps_pkg::HPS_LANE_NONE: tx_word        <= tx_word;
      endcase
    end
  end

  // DSP receive word; overwritten only when the DSP side is empty
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dsp_side_receive_word <= hps_pkg::WORD_EMPTY;
    end else if (part_rst) begin
      dsp_side_receive_word <= hps_pkg::WORD_EMPTY;
    end else if (move_tx) begin
      dsp_side_receive_word <= tx_word;
    end
  end

  // Vector survives individual and stop resets
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vector <= hps_pkg::VECTOR_RESET;
    end else if (soft_rst) begin
      vector <= hps_pkg::VECTOR_RESET;
    end else if (host_wr && host_addr == hps_pkg::ADDR_VECTOR) begin
      vector <= host_data_in;
    end
  end

  // DSP flags, sampled from the DSP each cycle; hard or soft reset clears them, stop resets do not
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_two   <= 1'b0;
      flag_three <= 1'b0;
    end else if (soft_rst) begin
      flag_two   <= 1'b0;
      flag_three <= 1'b0;
    end else begin
      flag_two   <= dsp_flag_two;
      flag_three <= dsp_flag_three;
    end
  end

  // Request pins; dual mode splits them, the combined pin then idles
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      combined_request_out <= 1'b0;
      transmit_request_out <= 1'b0;
      receive_request_out  <= 1'b0;
    end else begin
      combined_request_out <= ~dual_request_select & (next_rx_req | next_tx_req);
      transmit_request_out <= dual_request_select & next_tx_req;
      receive_request_out  <= dual_request_select & next_rx_req;
    end
  end

  // Bit 7 shows whichever pin set is active
  assign req_now = (rx_full_flag & receive_request_enable)
                 | (tx_empty_flag & transmit_request_enable);

  localparam int ST_POS_RX  = hps_pkg::ST_RX_FULL;
  localparam int ST_POS_TX  = hps_pkg::ST_TX_EMPTY;
  localparam int ST_POS_RDY = hps_pkg::ST_TX_READY;
  localparam int ST_POS_F2  = hps_pkg::ST_FLAG_TWO;
  localparam int ST_POS_F3  = hps_pkg::ST_FLAG_THREE;
  localparam int ST_POS_REQ = hps_pkg::ST_REQUEST;

  // Flags stay visible whatever the enables are
  always_comb begin
    status                = 8'h00;
    status[ST_POS_RX]     = rx_full_flag;
    status[ST_POS_TX]     = tx_empty_flag;
    status[ST_POS_RDY]    = tx_empty_flag & ~dsp_side_receive_full;
    status[ST_POS_F2]     = flag_two;
    status[ST_POS_F3]     = flag_three;
    status[ST_POS_REQ]    = req_now;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    read_value = pick_byte(rx_word, rd_lane);
    if (host_addr == hps_pkg::ADDR_STATUS) begin
      read_value = status;
    end else if (host_addr == hps_pkg::ADDR_VECTOR) begin
      read_value = vector;
    end
  end

  // A host read wins over acknowledge; the vector is driven only in cycles without a read
  assign vector_cycle = host_acknowledge_in
                      & (combined_request_out | transmit_request_out);

  // Status address writes fall through every decode above
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else if (host_rd) begin
      host_data_out <= read_value;
      host_data_oe  <= 1'b1;
    end else if (vector_cycle) begin
      host_data_out <= vector;
      host_data_oe  <= 1'b1;
    end else begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end
  end

  // Checks

  a_rx_full_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (load_rx && !part_rst) |=> rx_full_flag)
    else $error("receive-full not set by DSP word");

  a_rx_full_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_last && rx_full_flag) |=> !rx_full_flag)
    else $error("receive-full not cleared by last byte read");

  a_tx_empty_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_last && !part_rst && !init_tx && tx_empty_flag) |=> !tx_empty_flag)
    else $error("transmit-empty not cleared by last byte write");

  a_word_move: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!tx_empty_flag && !dsp_side_receive_full && !part_rst)
    |=> tx_empty_flag && dsp_side_receive_full
        && dsp_side_receive_word == $past(tx_word))
    else $error("transmit word not moved to DSP side");

  a_ready_value: assert property (@(posedge ref_clk) disable iff (sys_rst)
    transmitter_ready == (tx_empty_flag && !dsp_side_receive_full))
    else $error("transmitter ready wrong");

  a_vector_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (host_acknowledge_in && combined_request_out && !host_rd)
    |=> host_data_oe && host_data_out == $past(vector))
    else $error("vector not driven on acknowledge");

  a_vector_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    soft_rst |=> vector == hps_pkg::VECTOR_RESET)
    else $error("vector not reset");

  a_part_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (stop_rst || !interface_enable)
    |=> tx_empty_flag && !rx_full_flag && transmitter_ready
        && rx_word == hps_pkg::WORD_EMPTY)
    else $error("reset state wrong");

  a_request_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!receive_request_enable && !transmit_request_enable)
    |=> !combined_request_out && !transmit_request_out
        && !receive_request_out)
    else $error("request driven while disabled");

  a_status_zeros: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (host_rd && host_addr == hps_pkg::ADDR_STATUS)
    |=> host_data_out[6:5] == 2'h0 && host_data_out[7] == $past(req_now))
    else $error("status reserved or request bit wrong");

endmodule : hps_port

`default_nettype wire

// ---- shared/hps_pkg.sv ----
// Constants for the host port status and data byte block
package hps_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int WORD_W = 24;

  // Host address map
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_VECTOR = 3'h3;
  localparam logic [2:0] ADDR_BYTE_A = 3'h5;
  localparam logic [2:0] ADDR_BYTE_B = 3'h6;
  localparam logic [2:0] ADDR_BYTE_C = 3'h7;

  // Reset values
  localparam logic [7:0]  VECTOR_RESET = 8'h0f;
  localparam logic [23:0] WORD_EMPTY   = 24'h000000;

  // Status bit positions
  localparam int ST_RX_FULL    = 0;
  localparam int ST_TX_EMPTY   = 1;
  localparam int ST_TX_READY   = 2;
  localparam int ST_FLAG_TWO   = 3;
  localparam int ST_FLAG_THREE = 4;
  localparam int ST_REQUEST    = 7;

  // Byte lanes of a 24-bit word
  typedef enum logic [3:0] {
    HPS_LANE_HIGH = 4'h1,
    HPS_LANE_MID  = 4'h2,
    HPS_LANE_LOW  = 4'h4,
    HPS_LANE_NONE = 4'h8
  } hps_lane_t;

endpackage : hps_pkg

// ---- test/hps_host_model.sv ----
// Host processor model for the byte-wide host bus
`timescale 1ns/1ps
`default_nettype none

module hps_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe,
  output logic      [2:0] host_addr,
  output logic            host_rd,
  output logic            host_wr,
  output logic      [7:0] host_data_in,
  output logic            host_acknowledge_in
);
  initial begin
    host_addr = 3'h0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_data_in = 8'h00;
    host_acknowledge_in = 1'b0;
  end

  // Data is inverted after the strobe so a stale byte is never taken
  task automatic write_byte(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_data_in <= d;
    host_wr <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    host_data_in <= ~d;
  endtask : write_byte

  // Byte is taken one cycle after the strobe, only while the port drives
  task automatic read_byte(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    #1;
    d = (host_data_oe === 1'b1) ? host_data_out : 8'hxx;
  endtask : read_byte

  task automatic set_ack(input logic v);
    @(posedge ref_clk);
    host_acknowledge_in <= v;
  endtask : set_ack
endmodule : hps_host_model

`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the host port block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        ref_clk, sys_rst, soft_rst, stop_rst, interface_enable;
  logic [2:0]  host_addr;
  logic        host_rd, host_wr, host_data_oe, host_acknowledge_in;
  logic [7:0]  host_data_in, host_data_out;
  logic        receive_request_enable, transmit_request_enable;
  logic        byte_order_select, dual_request_select, init_cmd;
  logic        dsp_flag_two, dsp_flag_three, dsp_tx_write, dsp_rx_read;
  logic [23:0] dsp_side_transmit_word, dsp_side_receive_word, w, t;
  logic        dsp_side_receive_full, rx_full_flag, tx_empty_flag, transmitter_ready;
  logic        combined_request_out, transmit_request_out, receive_request_out;
  int          mismatches = 0;
  int          total_checks = 0;

  hps_port hps_port_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
    .stop_rst(stop_rst), .interface_enable(interface_enable), .host_addr(host_addr),
    .host_rd(host_rd), .host_wr(host_wr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .host_acknowledge_in(host_acknowledge_in), .receive_request_enable(receive_request_enable),
    .transmit_request_enable(transmit_request_enable), .byte_order_select(byte_order_select),
    .dual_request_select(dual_request_select), .init_cmd(init_cmd),
    .dsp_flag_two(dsp_flag_two), .dsp_flag_three(dsp_flag_three),
    .dsp_side_transmit_word(dsp_side_transmit_word), .dsp_tx_write(dsp_tx_write),
    .dsp_side_receive_word(dsp_side_receive_word), .dsp_side_receive_full(dsp_side_receive_full),
    .dsp_rx_read(dsp_rx_read), .rx_full_flag(rx_full_flag), .tx_empty_flag(tx_empty_flag),
    .transmitter_ready(transmitter_ready), .combined_request_out(combined_request_out),
    .transmit_request_out(transmit_request_out), .receive_request_out(receive_request_out));

  hps_host_model hps_host_model_i (.ref_clk(ref_clk), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
    .host_data_in(host_data_in), .host_acknowledge_in(host_acknowledge_in));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] b;
    hps_host_model_i.read_byte(a, b);
    check_val({16'h0000, b}, {16'h0000, e});
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic dsp_send(input logic [23:0] v);
    @(posedge ref_clk);
    dsp_side_transmit_word <= v;
    dsp_tx_write <= 1'b1;
    @(posedge ref_clk);
    dsp_tx_write <= 1'b0;
    #1;
  endtask : dsp_send

  task automatic dsp_take();
    @(posedge ref_clk);
    dsp_rx_read <= 1'b1;
    @(posedge ref_clk);
    dsp_rx_read <= 1'b0;
    tick(2);
  endtask : dsp_take

  // Three bytes, address 7 last whatever the byte order
  task automatic host_word(input logic [23:0] v, input logic le);
    hps_host_model_i.write_byte(hps_pkg::ADDR_BYTE_A, le ? v[7:0] : v[23:16]);
    hps_host_model_i.write_byte(hps_pkg::ADDR_BYTE_B, v[15:8]);
    hps_host_model_i.write_byte(hps_pkg::ADDR_BYTE_C, le ? v[23:16] : v[7:0]);
    #1;
  endtask : host_word

  // Run is under two hundred cycles; this leaves ample margin
  initial begin
    #40000;
    mismatches++;
    conclude();
  end

  initial begin
    {soft_rst, stop_rst, init_cmd} = '0;
    {receive_request_enable, transmit_request_enable, byte_order_select} = '0;
    {dual_request_select, dsp_flag_two, dsp_flag_three, dsp_tx_write, dsp_rx_read} = '0;
    dsp_side_transmit_word = '0;
    interface_enable = 1'b1;
    sys_rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(hps_pkg::ADDR_STATUS, 8'h06);
    rd_chk(hps_pkg::ADDR_VECTOR, 8'h0f);
    dsp_flag_two <= 1'b1;
    hps_host_model_i.write_byte(hps_pkg::ADDR_STATUS, 8'h18);
    rd_chk(hps_pkg::ADDR_STATUS, 8'h0e);
    dsp_flag_three <= 1'b1;
    rd_chk(hps_pkg::ADDR_STATUS, 8'h1e);
    dsp_flag_three <= 1'b0;
    for (int le = 0; le < 2; le++) begin
      w = le ? 24'h9a7c3e : 24'h123456;
      t = le ? 24'h5b6d7f : 24'ha1b2c3;
      byte_order_select <= le[0];
      dsp_send(w);
      check_val(rx_full_flag, 1'b1);
      dsp_send(24'hffffff);
      rd_chk(hps_pkg::ADDR_BYTE_A, le ? w[7:0] : w[23:16]);
      rd_chk(hps_pkg::ADDR_BYTE_B, w[15:8]);
      check_val(rx_full_flag, 1'b1);
      rd_chk(hps_pkg::ADDR_BYTE_C, le ? w[23:16] : w[7:0]);
      check_val(rx_full_flag, 1'b0);
      host_word(t, le[0]);
      check_val(tx_empty_flag, 1'b0);
      tick(2);
      check_val(dsp_side_receive_word, t);
      check_val({tx_empty_flag, dsp_side_receive_full, transmitter_ready}, 3'b110);
      host_word(~t, le[0]);
      tick(2);
      check_val({tx_empty_flag, transmitter_ready, dsp_side_receive_word}, {2'b00, t});
      dsp_take();
      check_val({tx_empty_flag, dsp_side_receive_word}, {1'b1, ~t});
      dsp_take();
    end
    transmit_request_enable <= 1'b1;
    tick(1);
    check_val(combined_request_out, 1'b1);
    rd_chk(hps_pkg::ADDR_STATUS, 8'h8e);
    hps_host_model_i.set_ack(1'b1);
    tick(2);
    check_val({host_data_oe, host_data_out}, 9'h10f);
    hps_host_model_i.set_ack(1'b0);
    hps_host_model_i.write_byte(hps_pkg::ADDR_VECTOR, 8'h5a);
    hps_host_model_i.set_ack(1'b1);
    tick(2);
    check_val({host_data_oe, host_data_out}, 9'h15a);
    hps_host_model_i.set_ack(1'b0);
    dual_request_select <= 1'b1;
    tick(2);
    check_val({combined_request_out, transmit_request_out, receive_request_out}, 3'b010);
    rd_chk(hps_pkg::ADDR_STATUS, 8'h8e);
    transmit_request_enable <= 1'b0;
    receive_request_enable <= 1'b1;
    dsp_send(24'h0f1e2d);
    check_val({transmit_request_out, receive_request_out}, 2'b01);
    rd_chk(hps_pkg::ADDR_STATUS, 8'h8f);
    transmit_request_enable <= 1'b1;
    hps_host_model_i.write_byte(hps_pkg::ADDR_BYTE_C, 8'h11);
    hps_host_model_i.write_byte(hps_pkg::ADDR_BYTE_C, 8'h22);
    tick(2);
    check_val({rx_full_flag, tx_empty_flag, dsp_side_receive_full}, 3'b101);
    init_cmd <= 1'b1;
    @(posedge ref_clk);
    init_cmd <= 1'b0;
    tick(1);
    check_val({rx_full_flag, tx_empty_flag, dsp_side_receive_full}, 3'b010);
    receive_request_enable <= 1'b0;
    transmit_request_enable <= 1'b0;
    dsp_send(24'h332211);
    stop_rst <= 1'b1;
    @(posedge ref_clk);
    stop_rst <= 1'b0;
    rd_chk(hps_pkg::ADDR_VECTOR, 8'h5a);
    rd_chk(hps_pkg::ADDR_STATUS, 8'h0e);
    transmit_request_enable <= 1'b1;
    dsp_send(24'h445566);
    interface_enable <= 1'b0;
    @(posedge ref_clk);
    interface_enable <= 1'b1;
    rd_chk(hps_pkg::ADDR_STATUS, 8'h8e);
    transmit_request_enable <= 1'b0;
    // Software reset also clears the DSP control register feeding the flags
    dsp_flag_two <= 1'b0;
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    rd_chk(hps_pkg::ADDR_VECTOR, 8'h0f);
    rd_chk(hps_pkg::ADDR_STATUS, 8'h06);
    conclude();
  end
endmodule : testbench

`default_nettype wire
